/* design/omc_pkg.sv */
package omc_pkg;

  // Bus address of the thermometer; the value is an arbitrary choice.
  localparam logic [6:0] OMC_DEV_ADDR = 7'h4a;

  // Command, pointer and data bytes that follow an addressed write header.
  localparam logic [7:0] OMC_CMD_START_CONV = 8'h51;
  localparam logic [7:0] OMC_CMD_COPY_NV = 8'h48;
  localparam logic [7:0] OMC_CMD_STOP_CONV = 8'h22;
  localparam logic [7:0] OMC_PTR_CFG_MSB = 8'hac;
  localparam logic [7:0] OMC_CFG_SINGLE_DATA = 8'h01;

  // Layout and reset value of the configuration upper byte.
  localparam int OMC_CFG_MODE_BIT = 0;
  localparam int OMC_CFG_BUSY_BIT = 7;
  localparam logic [7:0] OMC_CFG_RST = 8'h00;

  // Clock rates and the derived quarter period of the serial clock.
  localparam int OMC_CLK_HZ = 20000000;
  localparam int OMC_SCL_HZ = 100000;
  localparam int OMC_QTR_CYC = OMC_CLK_HZ / (4 * OMC_SCL_HZ);

  // Least wait after the copy command before the halt command.
  localparam int OMC_COPY_WAIT_MS = 10;
  localparam int OMC_COPY_WAIT_CYC = OMC_CLK_HZ / 1000 * OMC_COPY_WAIT_MS;

  // Default model durations of a conversion and a nonvolatile write.
  localparam int OMC_CONV_CYC = 4000;
  localparam int OMC_NV_WRITE_CYC = 2000;

  // Kinds of items in the master's command script, and the index of its last item.
  localparam logic [1:0] OMC_IT_START = 2'h0;
  localparam logic [1:0] OMC_IT_BYTE = 2'h1;
  localparam logic [1:0] OMC_IT_WAIT = 2'h2;
  localparam logic [1:0] OMC_IT_STOP = 2'h3;
  localparam logic [3:0] OMC_IT_LAST = 4'he;

  // States of the device end and of the master end.
  typedef enum logic [2:0] {
    OMC_D_IDLE, OMC_D_RX, OMC_D_ACK, OMC_D_TX, OMC_D_IGN
  } omc_dst_t;
  typedef enum logic [2:0] {
    OMC_M_IDLE, OMC_M_START, OMC_M_BIT, OMC_M_WAIT, OMC_M_STOP
  } omc_mst_t;

endpackage : omc_pkg

/* design/omc_twi_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface omc_twi_if;
  logic scl_out;
  logic scl_oe;
  logic m_sda_out;
  logic m_sda_oe;
  logic d_sda_out;
  logic d_sda_oe;
  logic scl;
  logic sda;

  // Open-drain wires: any enabled driver sending a zero pulls the line low.
  assign scl = (scl_oe && !scl_out) ? 1'b0 : 1'b1;
  assign sda = ((m_sda_oe && !m_sda_out) || (d_sda_oe && !d_sda_out)) ?
               1'b0 : 1'b1;

  modport master (output scl_out, scl_oe, m_sda_out, m_sda_oe,
                  input scl, sda);
  modport device (output d_sda_out, d_sda_oe, input scl, sda);
endinterface : omc_twi_if
`default_nettype wire

/* design/omc_master.sv */
`timescale 1ns/1ps
`default_nettype none
module omc_master
  import omc_pkg::*;
#(
  parameter int COPY_WAIT_CYC = OMC_COPY_WAIT_CYC
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // User side.
  input wire logic go_i,
  output logic busy_o,
  output logic done_o,
  output logic ack_err_o,
  // Serial bus.
  omc_twi_if.master twi
);

  localparam int WW = $clog2(COPY_WAIT_CYC + 1);
  localparam int QW = $clog2(OMC_QTR_CYC + 1);

  typedef struct packed {
    logic [1:0] sda_s;
    omc_mst_t st;
    logic [1:0] ph;
    logic [QW-1:0] qcnt;
    logic [3:0] bitc;
    logic [3:0] idx;
    logic [WW-1:0] wcnt;
    logic ack_low;
    logic scl_oe;
    logic sda_oe;
    logic busy;
    logic done;
    logic err;
  } omc_mstate_t;

  omc_mstate_t s_q;
  omc_mstate_t s_d;

  // Script item: kind in the top two bits, byte below.
  function automatic logic [9:0] omc_item(input logic [3:0] i);
    logic [7:0] a;
    a = {OMC_DEV_ADDR, 1'b0};
    case (i)
      4'h0, 4'h3, 4'h7, 4'hb: omc_item = {OMC_IT_START, 8'h00};
      4'h1, 4'h4, 4'h8, 4'hc: omc_item = {OMC_IT_BYTE, a};
      4'h2: omc_item = {OMC_IT_BYTE, OMC_CMD_START_CONV};
      4'h5: omc_item = {OMC_IT_BYTE, OMC_PTR_CFG_MSB};
      4'h6: omc_item = {OMC_IT_BYTE, OMC_CFG_SINGLE_DATA};
      4'h9: omc_item = {OMC_IT_BYTE, OMC_CMD_COPY_NV};
      4'ha: omc_item = {OMC_IT_WAIT, 8'h00};
      4'hd: omc_item = {OMC_IT_BYTE, OMC_CMD_STOP_CONV};
      default: omc_item = {OMC_IT_STOP, 8'h00};
    endcase
  endfunction : omc_item

  // Next state of the whole master.
  always_comb begin
    logic [9:0] it;
    logic [9:0] nx;
    logic tick;
    s_d = s_q;
    it = omc_item(s_q.idx);
    nx = omc_item(s_q.idx + 4'h1);
    tick = (s_q.qcnt == QW'(OMC_QTR_CYC - 1));
    s_d.sda_s = {s_q.sda_s[0], twi.sda};
    s_d.done = 1'b0;
    if (s_q.st != OMC_M_IDLE && s_q.st != OMC_M_WAIT) begin
      s_d.qcnt = tick ? '0 : s_q.qcnt + QW'(1);
      if (tick) begin
        s_d.ph = s_q.ph + 2'h1;
      end
    end
    case (s_q.st)
      OMC_M_IDLE: begin
        if (go_i) begin
          s_d = '0;
          s_d.sda_s = {s_q.sda_s[0], twi.sda};
          s_d.st = OMC_M_START;
          s_d.busy = 1'b1;
        end
      end
      OMC_M_START: begin
        if (tick) begin
          case (s_q.ph)
            2'h0: s_d.sda_oe = 1'b0;
            2'h1: s_d.scl_oe = 1'b0;
            2'h2: s_d.sda_oe = 1'b1;
            default: begin
              s_d.scl_oe = 1'b1;
              s_d.idx = s_q.idx + 4'h1;
              s_d.bitc = 4'h0;
              s_d.st = OMC_M_BIT;
            end
          endcase
        end
      end
      OMC_M_BIT: begin
        if (tick) begin
          case (s_q.ph)
            2'h0: s_d.sda_oe = (s_q.bitc < 4'h8) ?
                               !it[3'h7 - s_q.bitc[2:0]] : 1'b0;
            2'h1: s_d.scl_oe = 1'b0;
            2'h2: s_d.ack_low = !s_q.sda_s[1];
            default: begin
              s_d.scl_oe = 1'b1;
              s_d.bitc = s_q.bitc + 4'h1;
              if (s_q.bitc == 4'h8) begin
                s_d.bitc = 4'h0;
                if (!s_q.ack_low) begin
                  s_d.err = 1'b1;
                  s_d.st = OMC_M_STOP;
                end else begin
                  s_d.idx = s_q.idx + 4'h1;
                  case (nx[9:8])
                    OMC_IT_START: s_d.st = OMC_M_START;
                    OMC_IT_WAIT: s_d.st = OMC_M_WAIT;
                    OMC_IT_STOP: s_d.st = OMC_M_STOP;
                    default: s_d.st = OMC_M_BIT;
                  endcase
                end
              end
            end
          endcase
        end
      end
      OMC_M_WAIT: begin
        // Hold the bus with the clock low while the copy completes.
        s_d.wcnt = s_q.wcnt + WW'(1);
        if (s_q.wcnt == WW'(COPY_WAIT_CYC - 1)) begin
          s_d.wcnt = '0;
          s_d.idx = s_q.idx + 4'h1;
          s_d.st = OMC_M_START;
        end
      end
      default: begin
        if (tick) begin
          case (s_q.ph)
            2'h0: s_d.sda_oe = 1'b1;
            2'h1: s_d.scl_oe = 1'b0;
            2'h2: s_d.sda_oe = 1'b0;
            default: begin
              s_d.st = OMC_M_IDLE;
              s_d.busy = 1'b0;
              s_d.done = 1'b1;
              s_d.idx = OMC_IT_LAST;
            end
          endcase
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
      s_q.sda_s <= 2'h3;
    end else begin
      s_q <= s_d;
    end
  end

  assign twi.scl_out = 1'b0;
  assign twi.m_sda_out = 1'b0;
  assign twi.scl_oe = s_q.scl_oe;
  assign twi.m_sda_oe = s_q.sda_oe;
  assign busy_o = s_q.busy;
  assign done_o = s_q.done;
  assign ack_err_o = s_q.err;

endmodule : omc_master
`default_nettype wire

/* design/omc_device.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Master opens with start, write address.
// - Master uses repeated start between commands.
// - Master sends 51h to start conversions.
// - Device acknowledges 51h and starts converting.
// - ACh selects configuration upper byte shadow.
// - Data bit zero high selects single-conversion.
// - Device acknowledges every received byte of a transfer to its own address; a header with another address gets no ack.
// - 48h copies shadow into nonvolatile memory.
// - 22h stops continuous conversions.
// - Master waits 10ms after copy first.
// - Device shows nonvolatile busy flag in config.
// - Data bit zero low selects continuous.
module omc_device
  import omc_pkg::*;
#(
  parameter int CONV_CYC = OMC_CONV_CYC,
  parameter int NV_WRITE_CYC = OMC_NV_WRITE_CYC
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Serial bus.
  omc_twi_if.device twi,
  // Thermometer core side.
  output logic conv_active_o,
  output logic conv_done_o,
  output logic single_conversion_mode_bit_o,
  output logic nonvolatile_busy_flag_o,
  output logic [7:0] nv_cfg_o
);

  localparam int CW = $clog2(CONV_CYC + 1);
  localparam int NW = $clog2(NV_WRITE_CYC + 1);

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    omc_dst_t st;
    logic [3:0] bitc;
    logic [1:0] bidx;
    logic [7:0] sh;
    logic [7:0] tx;
    logic is_read;
    logic ptr_cfg;
    logic sda_oe;
    logic [7:0] shadow;
    logic [7:0] nv;
    logic nv_busy;
    logic [NW-1:0] nv_cnt;
    logic conv;
    logic conv_done;
    logic [CW-1:0] conv_cnt;
  } omc_dstate_t;

  omc_dstate_t s_q;
  omc_dstate_t s_d;

  // Configuration byte as a read shows it, with the live busy flag.
  function automatic logic [7:0] omc_cfg_view(input logic [7:0] sh,
                                              input logic busy);
    logic [7:0] v;
    v = sh;
    v[OMC_CFG_BUSY_BIT] = busy;
    omc_cfg_view = v;
  endfunction : omc_cfg_view

  // Next state: bus front end, byte interpreter and the two engines.
  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [7:0] cfg_rd;
    s_d = s_q;
    // Stage 0 is only ever read by stage 1 of the synchroniser.
    s_d.scl_s = {s_q.scl_s[1:0], twi.scl};
    s_d.sda_s = {s_q.sda_s[1:0], twi.sda};
    scl_rise = s_q.scl_s[1] && !s_q.scl_s[2];
    scl_fall = !s_q.scl_s[1] && s_q.scl_s[2];
    start_c = s_q.scl_s[1] && s_q.sda_s[2] && !s_q.sda_s[1];
    stop_c = s_q.scl_s[1] && !s_q.sda_s[2] && s_q.sda_s[1];
    cfg_rd = omc_cfg_view(s_q.shadow, s_q.nv_busy);
    s_d.conv_done = 1'b0;

    // Conversion engine; single mode drops out after one result.
    if (s_q.conv) begin
      s_d.conv_cnt = s_q.conv_cnt + CW'(1);
      if (s_q.conv_cnt == CW'(CONV_CYC - 1)) begin
        s_d.conv_cnt = '0;
        s_d.conv_done = 1'b1;
        if (s_q.shadow[OMC_CFG_MODE_BIT]) begin
          s_d.conv = 1'b0;
        end
      end
    end

    // Nonvolatile write engine; the copy lands when the write ends.
    if (s_q.nv_busy) begin
      s_d.nv_cnt = s_q.nv_cnt - NW'(1);
      if (s_q.nv_cnt == NW'(1)) begin
        s_d.nv_busy = 1'b0;
        s_d.nv = s_q.shadow;
      end
    end

    // Bus front end; start and stop override any byte in progress.
    if (start_c) begin
      s_d.st = OMC_D_RX;
      s_d.bitc = 4'h0;
      s_d.bidx = 2'h0;
      s_d.ptr_cfg = 1'b0;
      s_d.sda_oe = 1'b0;
    end else if (stop_c) begin
      s_d.st = OMC_D_IDLE;
      s_d.sda_oe = 1'b0;
    end else begin
      case (s_q.st)
        OMC_D_RX: begin
          if (scl_rise && s_q.bitc < 4'h8) begin
            s_d.sh = {s_q.sh[6:0], s_q.sda_s[1]};
            s_d.bitc = s_q.bitc + 4'h1;
          end else if (scl_fall && s_q.bitc == 4'h8) begin
            s_d.st = OMC_D_ACK;
            s_d.sda_oe = 1'b1;
            if (s_q.bidx == 2'h0) begin
              s_d.is_read = s_q.sh[0];
              if (s_q.sh[7:1] != OMC_DEV_ADDR) begin
                s_d.st = OMC_D_IGN;
                s_d.sda_oe = 1'b0;
              end
            end else if (s_q.bidx == 2'h1) begin
              // Command byte.
              if (s_q.sh == OMC_CMD_START_CONV) begin
                s_d.conv = 1'b1;
                s_d.conv_cnt = '0;
              end else if (s_q.sh == OMC_CMD_STOP_CONV) begin
                s_d.conv = 1'b0;
                s_d.conv_cnt = '0;
              end else if (s_q.sh == OMC_CMD_COPY_NV) begin
                s_d.nv_busy = 1'b1;
                s_d.nv_cnt = NW'(NV_WRITE_CYC);
              end else if (s_q.sh == OMC_PTR_CFG_MSB) begin
                s_d.ptr_cfg = 1'b1;
              end
            end else if (s_q.ptr_cfg) begin
              // Data for the configuration shadow byte.
              s_d.shadow = s_q.sh;
            end
          end
        end
        OMC_D_ACK: begin
          // After the acknowledge clock pulse ends, release, or on a read drive the first data bit.
          if (scl_fall) begin
            s_d.bitc = 4'h0;
            if (s_q.is_read) begin
              s_d.st = OMC_D_TX;
              s_d.sda_oe = !cfg_rd[7];
              s_d.tx = {cfg_rd[6:0], 1'b0};
            end else begin
              s_d.st = OMC_D_RX;
              s_d.sda_oe = 1'b0;
              if (s_q.bidx != 2'h3) begin
                s_d.bidx = s_q.bidx + 2'h1;
              end
            end
          end
        end
        OMC_D_TX: begin
          if (scl_rise) begin
            s_d.bitc = s_q.bitc + 4'h1;
          end else if (scl_fall) begin
            if (s_q.bitc == 4'h8) begin
              s_d.st = OMC_D_IGN;
              s_d.sda_oe = 1'b0;
            end else begin
              s_d.sda_oe = !s_q.tx[7];
              s_d.tx = {s_q.tx[6:0], 1'b0};
            end
          end
        end
        default: begin
          s_d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // State register; the bus lines idle high.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
      s_q.scl_s <= 3'h7;
      s_q.sda_s <= 3'h7;
      s_q.st <= OMC_D_IDLE;
      s_q.shadow <= OMC_CFG_RST;
      s_q.nv <= OMC_CFG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register.
  assign twi.d_sda_out = 1'b0;
  assign twi.d_sda_oe = s_q.sda_oe;
  assign conv_active_o = s_q.conv;
  assign conv_done_o = s_q.conv_done;
  assign single_conversion_mode_bit_o = s_q.shadow[OMC_CFG_MODE_BIT];
  assign nonvolatile_busy_flag_o = s_q.nv_busy;
  assign nv_cfg_o = s_q.nv;

endmodule : omc_device
`default_nettype wire

/* bench/omc_seq_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module omc_seq_properties
  import omc_pkg::*;
#(
  parameter int COPY_WAIT_CYC = OMC_COPY_WAIT_CYC
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Bus signals of the joined pair.
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic m_sda_out,
  input wire logic m_sda_oe,
  input wire logic d_sda_out,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, rise, start_ev, stop_ev, eb_ok;
  logic [3:0] bit_q;
  logic [2:0] byte_q, txn_q;
  // Wide enough to count past the copy wait at any parameter value.
  localparam int WQ = $clog2(COPY_WAIT_CYC + 2);
  logic [WQ-1:0] wait_q;
  logic [7:0] eb;

  // Clock rise, start and stop as seen on the wires.
  assign rise = scl && !scl_q;
  assign start_ev = scl && scl_q && sda_q && !sda;
  assign stop_ev = scl && scl_q && !sda_q && sda;

  // Bit, byte and transaction position, and time since the copy ack.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bit_q <= 4'h0;
      byte_q <= 3'h0;
      txn_q <= 3'h0;
      wait_q <= '0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_ev) begin
        bit_q <= 4'h0;
        byte_q <= 3'h0;
        txn_q <= txn_q + 3'h1;
      end else if (stop_ev) begin
        txn_q <= 3'h0;
      end else if (rise) begin
        bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
        byte_q <= (bit_q == 4'h8) ? byte_q + 3'h1 : byte_q;
      end
      if (rise && txn_q == 3'h3 && byte_q == 3'h1 && bit_q == 4'h8) begin
        wait_q <= '0;
      end else if (wait_q != {WQ{1'b1}}) begin
        wait_q <= wait_q + WQ'(1);
      end
    end
  end

  // Expected byte at each place of the script; other places go unchecked.
  always_comb begin
    case ({txn_q, byte_q})
      6'h09: eb = OMC_CMD_START_CONV;
      6'h11: eb = OMC_PTR_CFG_MSB;
      6'h12: eb = OMC_CFG_SINGLE_DATA;
      6'h19: eb = OMC_CMD_COPY_NV;
      6'h21: eb = OMC_CMD_STOP_CONV;
      default: eb = {OMC_DEV_ADDR, 1'b0};
    endcase
  end
  assign eb_ok = (txn_q != 3'h0) && (byte_q == 3'h0 ||
                 {txn_q, byte_q} inside {6'h09, 6'h11, 6'h12, 6'h19, 6'h21});

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  property p_hdr;
    rise && eb_ok && byte_q == 3'h0 && bit_q < 4'h8 |-> sda == eb[4'h7 - bit_q];
  endproperty
  a_hdr: assert property (p_hdr)
    else $error("header bit differs from write address");
  property p_cmd;
    rise && eb_ok && byte_q != 3'h0 && bit_q < 4'h8 |-> sda == eb[4'h7 - bit_q];
  endproperty
  a_cmd: assert property (p_cmd)
    else $error("command or data bit out of script order");
  property p_ack;
    rise && eb_ok && bit_q == 4'h8 |-> !sda;
  endproperty
  a_ack: assert property (p_ack)
    else $error("byte not acknowledged");
  property p_ack_due;
    $fell(scl) && eb_ok && bit_q == 4'h8 |-> ##[1:4] d_sda_oe;
  endproperty
  a_ack_due: assert property (p_ack_due)
    else $error("device ack came late");
  property p_ack_hold;
    scl && $past(scl) |-> $stable(d_sda_oe);
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("device data moved while clock high");
  property p_start_hold;
    start_ev |=> scl [*8];
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("clock fell too soon after start");
  property p_copy_wait;
    start_ev && txn_q == 3'h3 |-> wait_q >= COPY_WAIT_CYC;
  endproperty
  a_copy_wait: assert property (p_copy_wait)
    else $error("halt sent before copy wait ended");
  property p_stop_end;
    stop_ev |-> txn_q == 3'h4 && byte_q == 3'h2;
  endproperty
  a_stop_end: assert property (p_stop_end)
    else $error("stop outside end of script");
  property p_idle;
    stop_ev |=> (scl && sda) [*8];
  endproperty
  a_idle: assert property (p_idle)
    else $error("bus not released after stop");
endmodule : omc_seq_properties
`default_nettype wire

/* bench/oneshot_mode_config_sequence_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, want) begin \
  samples_checked++; \
  if ((got) !== (want)) begin \
    miscompares++; \
    $display("[ERR] %0t got %0h want %0h", $time, got, want); \
  end \
end
module oneshot_mode_config_sequence_bench
  import omc_pkg::*;
;
  localparam int WAIT_CYC = 100;
  localparam logic [7:0] HDR_W = {OMC_DEV_ADDR, 1'b0};
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic go = 1'b0;
  logic f_scl_oe = 1'b0;
  logic f_sda_oe = 1'b0;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic saw_conv, saw_nvb, busy, done, ack_err, conv_active, conv_done;
  logic mode, nonvolatile_busy_flag, f_conv, f_nvb, f_mode;
  logic [7:0] nv_cfg;
  int miscompares = 0;
  int samples_checked = 0;
  int n_start, n_stop, n_conv;

  // Core clock of 50 ns.
  always #25 core_clk = ~core_clk;

  // Joined pair, and a lone device whose bus the bench drives.
  omc_twi_if i_omc_twi_if ();
  omc_twi_if i_omc_twi_if_f ();
  assign i_omc_twi_if_f.scl_out = 1'b0;
  assign i_omc_twi_if_f.m_sda_out = 1'b0;
  assign i_omc_twi_if_f.scl_oe = f_scl_oe;
  assign i_omc_twi_if_f.m_sda_oe = f_sda_oe;
  wire logic m_scl = i_omc_twi_if.scl;
  wire logic m_sda = i_omc_twi_if.sda;
  omc_master #(.COPY_WAIT_CYC(WAIT_CYC)) i_omc_master (
    .core_clk_i(core_clk), .rst_b_i(rst_b), .go_i(go), .busy_o(busy),
    .done_o(done), .ack_err_o(ack_err), .twi(i_omc_twi_if));
  omc_device #(.CONV_CYC(50), .NV_WRITE_CYC(40)) i_omc_device (
    .core_clk_i(core_clk), .rst_b_i(rst_b), .twi(i_omc_twi_if),
    .conv_active_o(conv_active), .conv_done_o(conv_done),
    .single_conversion_mode_bit_o(mode),
    .nonvolatile_busy_flag_o(nonvolatile_busy_flag), .nv_cfg_o(nv_cfg));
  omc_device #(.CONV_CYC(50), .NV_WRITE_CYC(2000)) i_omc_device_f (
    .core_clk_i(core_clk), .rst_b_i(rst_b), .twi(i_omc_twi_if_f),
    .conv_active_o(f_conv), .conv_done_o(),
    .single_conversion_mode_bit_o(f_mode),
    .nonvolatile_busy_flag_o(f_nvb), .nv_cfg_o());
  omc_seq_properties #(.COPY_WAIT_CYC(WAIT_CYC)) i_omc_seq_properties (
    .core_clk_i(core_clk), .rst_b_i(rst_b),
    .scl_out(i_omc_twi_if.scl_out), .scl_oe(i_omc_twi_if.scl_oe),
    .m_sda_out(i_omc_twi_if.m_sda_out), .m_sda_oe(i_omc_twi_if.m_sda_oe),
    .d_sda_out(i_omc_twi_if.d_sda_out), .d_sda_oe(i_omc_twi_if.d_sda_oe),
    .scl(m_scl), .sda(m_sda));

  // Counts starts, stops and core events of the joined pair.
  always @(posedge core_clk) begin
    scl_q <= m_scl;
    sda_q <= m_sda;
    if (scl_q && m_scl && sda_q && !m_sda) n_start++;
    if (scl_q && m_scl && !sda_q && m_sda) n_stop++;
    if (conv_done === 1'b1) n_conv++;
    if (conv_active === 1'b1) saw_conv = 1'b1;
    if (nonvolatile_busy_flag === 1'b1) saw_nvb = 1'b1;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("miscompares %0d samples_checked %0d", miscompares,
             samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // One quarter of the bench's own serial clock.
  task automatic q();
    repeat (10) @(negedge core_clk);
  endtask : q

  // One bit on the lone device's bus; a one releases the data line.
  task automatic f_bit(input logic b, output logic r);
    f_sda_oe = !b;
    q();
    f_scl_oe = 1'b0;
    q();
    r = i_omc_twi_if_f.sda;
    q();
    f_scl_oe = 1'b1;
    q();
  endtask : f_bit

  // Start or repeated start, ending with the clock held low.
  task automatic f_start();
    f_sda_oe = 1'b0;
    q();
    f_scl_oe = 1'b0;
    q();
    f_sda_oe = 1'b1;
    q();
    f_scl_oe = 1'b1;
    q();
  endtask : f_start

  // Stop condition, leaving both lines released.
  task automatic f_stop();
    f_sda_oe = 1'b1;
    q();
    f_scl_oe = 1'b0;
    q();
    f_sda_oe = 1'b0;
    q();
  endtask : f_stop

  // Eight bits MSB first, then the ack slot released.
  task automatic f_byte(input logic [7:0] v, output logic [7:0] rd,
                        output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      f_bit(v[i], r);
      rd[i] = r;
    end
    f_bit(1'b1, r);
    ack = !r;
  endtask : f_byte

  // Addressed write of one command byte, both bytes to be acknowledged.
  task automatic f_cmd(input logic [7:0] cmd);
    logic a;
    logic [7:0] rd;
    f_start();
    f_byte(HDR_W, rd, a);
    `CHK(a, 1'b1)
    f_byte(cmd, rd, a);
    `CHK(a, 1'b1)
  endtask : f_cmd

  // One master script with go held for three cycles, under a bounded wait.
  task automatic run_script();
    n_start = 0;
    n_stop = 0;
    n_conv = 0;
    saw_conv = 1'b0;
    saw_nvb = 1'b0;
    go = 1'b1;
    repeat (3) @(negedge core_clk);
    go = 1'b0;
    `CHK(busy, 1'b1)
    for (int n = 0; n < 40000 && done !== 1'b1; n++) @(negedge core_clk);
    if (done !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t script never finished", $time);
      stop_test();
    end
    `CHK(busy, 1'b0)
  endtask : run_script

  // From continuous mode after reset into single mode.
  task automatic t_enter_single();
    `CHK(m_scl & m_sda, 1'b1)
    `CHK(mode, 1'b0)
    run_script();
    `CHK(n_start, 4)
    `CHK(n_stop, 1)
    `CHK(ack_err, 1'b0)
    `CHK(saw_conv, 1'b1)
    `CHK(n_conv > 1, 1'b1)
    `CHK(mode, 1'b1)
    `CHK(saw_nvb, 1'b1)
    `CHK(nv_cfg, OMC_CFG_SINGLE_DATA)
    `CHK(nonvolatile_busy_flag, 1'b0)
  endtask : t_enter_single

  // Script again in single mode: one conversion only.
  task automatic t_single();
    run_script();
    `CHK(n_conv, 1)
    `CHK(conv_active, 1'b0)
    `CHK(n_start, 4)
  endtask : t_single

  // Lone device: wrong address, mode bit both ways, start and halt, busy read.
  task automatic t_fault();
    logic a;
    logic [7:0] rd;
    f_start();
    f_byte(HDR_W ^ 8'h02, rd, a);
    `CHK(a, 1'b0)
    f_stop();
    f_cmd(OMC_PTR_CFG_MSB);
    f_byte(8'hff, rd, a);
    `CHK(a, 1'b1)
    `CHK(f_mode, 1'b1)
    f_cmd(OMC_PTR_CFG_MSB);
    f_byte(8'h00, rd, a);
    `CHK(a, 1'b1)
    `CHK(f_mode, 1'b0)
    f_cmd(OMC_CMD_START_CONV);
    `CHK(f_conv, 1'b1)
    f_cmd(OMC_CMD_STOP_CONV);
    `CHK(f_conv, 1'b0)
    f_cmd(OMC_CMD_COPY_NV);
    f_start();
    f_byte(HDR_W | 8'h01, rd, a);
    `CHK(a, 1'b1)
    f_byte(8'hff, rd, a);
    `CHK(rd, 8'h80)
    f_stop();
    for (int n = 0; n < 2100 && f_nvb !== 1'b0; n++) @(negedge core_clk);
    `CHK(f_nvb, 1'b0)
  endtask : t_fault

  // Reset for three cycles, then the scenarios.
  initial begin
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
    t_enter_single();
    t_single();
    t_fault();
    stop_test();
  end
endmodule : oneshot_mode_config_sequence_bench
`default_nettype wire
